//--- verif/acl_ctl_model.sv
// Controller model: drives SYNC and output frames, collects input frames
`timescale 1ns/10ps
module acl_ctl_model (
	// Bench side
	input  wire logic         run_i,
	input  wire logic         warm_i,
	input  wire logic [255:0] tx_i,
	output logic      [255:0] rx_o,
	output logic      [7:0]   fcnt_o,
	// Link pins
	input  wire logic         bit_clk_i,
	input  wire logic         sdata_in_i,
	output logic              sync_o,
	output logic              sdata_out_o
);
	logic [7:0]   c_q;
	logic [255:0] cur_q = 256'h0;
	logic [255:0] sh_q;
	logic         sy_q  = 1'b0;

	assign sync_o = sy_q | warm_i;

	// ==========
	// Input bits are taken on the fall that follows their launch
	always @(negedge bit_clk_i) begin
		sh_q <= {sh_q[254:0], sdata_in_i};
	end

	// ==========
	// Framing
	always @(posedge bit_clk_i) begin
		if (!run_i) begin
			c_q         <= 8'h00;
			sy_q        <= 1'b0;
			sdata_out_o <= 1'b0;
			fcnt_o      <= 8'h00;
		end else begin
			c_q         <= c_q + 8'h01;
			sy_q        <= c_q < 8'h10;
			sdata_out_o <= cur_q[8'h00 - c_q];
			if (c_q == 8'h00)
				cur_q <= tx_i;
			if (c_q == 8'h01) begin
				rx_o   <= sh_q;
				fcnt_o <= fcnt_o + 8'h01;
			end
		end
	end
endmodule

//--- verif/tb_acl_codec.sv
// Self-checking bench for the AC-link secondary codec port
`timescale 1ns/10ps
module tb_acl_codec;
	import acl_pkg::*;
	logic         ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0]   paddr = 8'h00;
	logic [31:0]  pwdata = 32'h0, prdata, rd, seed = 32'h942D;
	logic         pready, pslverr, err, sync, sdo, sdi;
	logic         bclk = 1'b0, bclk_en = 1'b1, run = 1'b0, warm = 1'b0, rstn = 1'b1;
	logic [255:0] txf = 256'h0, rxf;
	logic [7:0]   fcnt;
	logic [6:0]   ix [4];
	logic [15:0]  dv [4];
	int           failures = 0, n_checks = 0;

	initial forever #10 ref_clk_i = ~ref_clk_i;
	initial begin
		#7;
		forever #80 bclk = bclk_en ? ~bclk : 1'b0;
	end

	acl_codec acl_codec_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .bit_clk_i(bclk), .sync_i(sync), .sdata_out_i(sdo), .reset_n_i(rstn),
		.sdata_in_o(sdi));
	acl_ctl_model acl_ctl_model_i (.run_i(run), .warm_i(warm), .tx_i(txf), .rx_o(rxf), .fcnt_o(fcnt),
		.bit_clk_i(bclk), .sdata_in_i(sdi), .sync_o(sync), .sdata_out_o(sdo));

	// ==========
	// Helpers
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [255:0] mkf(logic [15:0] tg, logic [19:0] s1, s2, s5);
		logic [255:0] f;
		f = {tg, 240'h0};
		f[239 -: 20] = s1;
		f[219 -: 20] = s2;
		f[159 -: 20] = s5;
		return f;
	endfunction

	task automatic chk(logic [255:0] seen, logic [255:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		@(posedge ref_clk_i);
		while (pready !== 1'b1)
			@(posedge ref_clk_i);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Sends one frame; returns with rxf holding the frame before it
	task automatic frame(logic [255:0] f);
		logic [7:0] n;
		@(posedge ref_clk_i);
		n = fcnt;
		txf <= f;
		wait (fcnt !== n);
		@(posedge ref_clk_i);
	endtask

	task automatic go();
		@(posedge ref_clk_i);
		bclk_en <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		run <= 1'b1;
	endtask

	task automatic halt();
		@(posedge ref_clk_i);
		run <= 1'b0;
		repeat (40) @(posedge ref_clk_i);
		bclk_en <= 1'b0;
		repeat (20) @(posedge ref_clk_i);
	endtask

	task automatic ready_chk();
		frame(256'h0);
		frame(256'h0);
		chk(rxf[255], 1'b0);
		frame(256'h0);
		frame(256'h0);
		chk(rxf, {1'b1, 255'h0});
	endtask

	// Reads back the four indices in ix; z expects cleared contents
	task automatic rdback(logic z);
		logic [15:0] e;
		for (int i = 0; i < 6; i++) begin
			frame(i < 4 ? mkf(16'hC000, {1'b1, ix[i], 12'h0}, 20'h0, 20'h0) : 256'h0);
			if (i >= 2) begin
				e = (z | ix[i-2][0]) ? 16'h0 : dv[i-2];
				chk(rxf, mkf(16'hE000, {1'b0, ix[i-2], 12'h0}, {e, 4'h0}, 20'h0));
			end
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		#2000000;
		failures++;
		results();
	end

	// ==========
	// Tests
	initial begin
		logic [31:0] r;
		logic [15:0] d;
		repeat (16) @(posedge ref_clk_i);
		chk(sdi, 1'b0);
		rst_i <= 1'b0;
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({err, rd}, {1'b1, 32'h0});
		$display("test apb done");
		go();
		ready_chk();
		r = rnd();
		ix = '{{4'h4, r[2:1], 1'b0}, 7'h00, 7'h7E, 7'h25};
		for (int i = 0; i < 4; i++) begin
			r = rnd();
			dv[i] = r[15:0];
			frame(mkf(16'hE000, {1'b0, ix[i], 12'h0}, {dv[i], 4'h0}, 20'h0));
		end
		rdback(1'b0);
		$display("test registers done");
		halt();
		warm <= 1'b1;
		repeat (60) @(posedge ref_clk_i);
		warm <= 1'b0;
		go();
		ready_chk();
		rdback(1'b0);
		$display("test warm reset done");
		apb(1'b1, ADDR_CTRL, 32'h1);
		frame(mkf(16'hE000, {1'b0, REG_RESET_IDX, 12'h0}, 20'hFFFF0, 20'h0));
		rdback(1'b1);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk(rd[0], 1'b1);
		$display("test register reset done");
		r = rnd();
		d = r[31:16];
		frame(mkf(16'h8400, 20'h0, 20'h0, {d, 4'h0}));
		// An untagged slot arrives as zeros and must leave the modem word alone
		frame(mkf(16'h8000, 20'h0, 20'h0, 20'h0));
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[1], 1'b1);
		apb(1'b0, ADDR_MRX, 32'h0);
		chk(rd[15:0], d);
		// A register write rides along so that the cold reset has something to clear
		frame(mkf(16'hE000, {1'b0, ix[0], 12'h0}, {dv[0], 4'h0}, 20'h0));
		apb(1'b0, ADDR_MRX, 32'h0);
		chk(rd[15:0], d);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk(rd[1], 1'b0);
		apb(1'b1, ADDR_MTX, {16'h0, ~d});
		frame(256'h0);
		frame(256'h0);
		chk(rxf, mkf(16'h8400, 20'h0, 20'h0, {~d, 4'h0}));
		frame(256'h0);
		chk(rxf, {1'b1, 255'h0});
		$display("test modem done");
		halt();
		rstn <= 1'b0;
		repeat (60) @(posedge ref_clk_i);
		rstn <= 1'b1;
		go();
		ready_chk();
		rdback(1'b1);
		$display("test cold reset done");
		results();
	end
endmodule

//--- verilog/acl_codec.sv
// AC-link secondary codec port: framing, slot handling, codec registers, APB view
// Notes on behaviour
// (R01) Frames hold a 16-bit tag slot and twelve 20-bit slots, 48 kHz.
// (R02) Bit clock is only an input; device never generates it.
// (R03) Controller makes SYNC by dividing bit clock by 256.
// (R04) Input-line data changes on bit clock rise; output line sampled on fall.
// (R05) Link reset low returns all logic, registers included, to defaults; en_q and prdata_q clear on rst_i only.
// (R06) SYNC high 1 us without bit clock restarts framing, registers kept.
// (R07) Write to index 3Ch restores only the register file.
// (R08) Controller waits for codec ready before modem traffic.
// (R09) 12.288 MHz bit clock, 256 bit periods per frame.
// (R10) Slot 0 tag bit set means matching slot carries valid data.
// (R11) Source drives zeros throughout any slot tagged invalid.
// (R12) Controller holds SYNC high 16 bits for tag phase.
// (R13) Register contents survive halted clock, SYNC and data.
// (R14) Output slot 0 bit 15 flags a frame with valid data.
// (R15) Twelve bits after frame-valid are tags for slots one to twelve.
// (R16) SYNC rise sampled on the fall; first bit follows next rise.
// (R17) Controller sends MSB first, invalid slots zero.
// (R18) Controller zero-pads short samples in valid slots.
// (R19) Slots 1-2 carry register access both ways, slot 5 modem data.
// (R20) Link uses bit clock, SYNC, data in, data out, reset_n.
// (R21) Input slot 0 bit 15 reports codec ready after reset settles.
// (R22) Slot 1 bit 19 read flag, 18:12 index; slot 2 19:4 data.
// (R23) Output slot 5 validity is tag bit 10.
// (R24) Bit counter cleared on sampled SYNC rise derives slot bounds.
// (R25) Input-line output zero in reset and in untagged slots.
`timescale 1ns/10ps
module acl_codec
	import acl_pkg::*;
(
	// System
	input  wire logic        ref_clk_i,
	input  wire logic        rst_i,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// AC-link pins
	input  wire logic        bit_clk_i,
	input  wire logic        sync_i,
	input  wire logic        sdata_out_i,
	input  wire logic        reset_n_i,
	output logic             sdata_in_o
);

	// ==========================================
	// Position decode
	function automatic acl_pos_t pos_decode(input logic [7:0] p);
		acl_pos_t r;
		logic [7:0] q;
		r = '0;
		q = p - 8'(TAG_BITS);
		if (p < 8'(TAG_BITS)) begin
			r.slot = 4'h0;
			r.bpos = 5'(TAG_BITS - 1) - p[4:0];
		end else begin
			r.slot = 4'(q / 8'(SLOT_BITS)) + 4'h1;
			r.bpos = 5'(SLOT_BITS - 1) - 5'(q % 8'(SLOT_BITS));
		end
		return r;
	endfunction

	// ==========================================
	// Pin synchronisers
	logic bclk_s1, bclk_s2, bclk_s3;
	logic sync_s1, sync_s2, sdo_s1, sdo_s2, rstn_s1, rstn_s2;

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			{bclk_s1, bclk_s2, bclk_s3} <= 3'h0;
			{sync_s1, sync_s2, sdo_s1, sdo_s2} <= 4'h0;
			{rstn_s1, rstn_s2} <= 2'h0;
		end else begin
			bclk_s1 <= bit_clk_i; // R02
			bclk_s2 <= bclk_s1;
			bclk_s3 <= bclk_s2;
			sync_s1 <= sync_i;
			sync_s2 <= sync_s1;
			sdo_s1  <= sdata_out_i;
			sdo_s2  <= sdo_s1;
			rstn_s1 <= reset_n_i;
			rstn_s2 <= rstn_s1;
		end
	end

	logic rise, fall, rst_all;
	assign rise    = bclk_s2 & ~bclk_s3; // R04
	assign fall    = ~bclk_s2 & bclk_s3;
	assign rst_all = rst_i | ~rstn_s2; // R05

	// ==========================================
	// Warm reset detect
	logic [7:0] idle_q;
	logic       warm;
	assign warm = (idle_q == 8'(WARM_CYC - 1)) & sync_s2 & ~rise & ~fall;

	always_ff @(posedge ref_clk_i) begin
		if (rst_all || rise || fall || !sync_s2) begin
			idle_q <= 8'h00;
		end else if (idle_q != 8'(WARM_CYC)) begin
			idle_q <= idle_q + 8'h01; // R06
		end
	end

	// ==========================================
	// Frame counter
	logic [8:0] pos_q;
	logic       sync_prev_q, frame_start, in_frame;
	acl_pos_t   pos;
	assign frame_start = fall & sync_s2 & ~sync_prev_q; // R16
	assign in_frame    = (pos_q != POS_IDLE); // R09
	assign pos         = pos_decode(pos_q[7:0]);

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			sync_prev_q <= 1'b0;
			pos_q       <= POS_IDLE;
		end else if (warm) begin
			sync_prev_q <= 1'b0;
			pos_q       <= POS_IDLE; // R06
		end else if (fall) begin
			sync_prev_q <= sync_s2;
			if (frame_start) begin
				pos_q <= 9'h000; // R24
			end else if (in_frame) begin
				pos_q <= pos_q + 9'h001; // R01
			end
		end
	end

	// ==========================================
	// Output-line receive
	logic [19:0] shift_q;
	logic [15:0] tags_q;
	acl_cmd_t    cmd_q;
	logic [19:0] rx_word;
	logic        rx_end;
	assign rx_word = {shift_q[18:0], sdo_s2};
	assign rx_end  = fall & in_frame & ~frame_start & (pos.bpos == 5'h00);

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			shift_q <= 20'h00000;
			tags_q  <= 16'h0000;
			cmd_q   <= '0;
		end else if (fall && in_frame && !frame_start) begin
			shift_q <= rx_word; // R04
			if (rx_end && pos.slot == 4'h0) begin
				tags_q <= rx_word[15:0]; // R15
			end
			if (rx_end && pos.slot == SLOT_CMD) begin
				cmd_q <= rx_word[19:12]; // R22
			end
		end
	end

	logic cmd_done, cmd_ok, reg_wr, rd_set;
	assign cmd_done = rx_end & (pos.slot == SLOT_DATA);
	assign cmd_ok   = cmd_done & tags_q[TAG_VALID] & tags_q[TAG_CMD]; // R14
	assign reg_wr   = cmd_ok & ~cmd_q.rd & tags_q[TAG_DATA] & ~cmd_q.idx[0];
	assign rd_set   = cmd_ok & cmd_q.rd;

	// ==========================================
	// Codec register file
	logic [15:0] regs_q [64];

	always_ff @(posedge ref_clk_i) begin
		if (rst_all || (reg_wr && cmd_q.idx == REG_RESET_IDX)) begin
			for (int i = 0; i < 64; i++) begin
				regs_q[i] <= REG_DEFAULT; // R05 R07
			end
		end else if (reg_wr) begin
			regs_q[cmd_q.idx[6:1]] <= rx_word[19:4]; // R19 R13
		end
	end

	// ==========================================
	// Modem slot and read return
	logic [15:0] mrx_q, mtx_q, rd_data_q;
	logic [6:0]  rd_idx_q;
	logic        mrx_new_q, mtx_pend_q, rd_pend_q, rd_v_q, md_v_q, en_q;
	logic        mrx_set, mrx_clr, mtx_set, apb_rd, apb_wr;
	assign apb_rd  = psel & ~penable & ~pwrite;
	assign apb_wr  = psel & penable & pwrite;
	assign mrx_set = rx_end & (pos.slot == SLOT_MODEM) & tags_q[TAG_MODEM]; // R23
	assign mrx_clr = apb_rd & (paddr == ADDR_MRX);
	assign mtx_set = apb_wr & (paddr == ADDR_MTX);

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			mrx_q     <= 16'h0000;
			mrx_new_q <= 1'b0;
		end else if (mrx_set) begin
			mrx_q     <= rx_word[19:4];
			mrx_new_q <= 1'b1;
		end else if (mrx_clr) begin
			mrx_new_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			rd_pend_q <= 1'b0;
			rd_idx_q  <= 7'h00;
		end else if (rd_set) begin
			rd_pend_q <= 1'b1;
			rd_idx_q  <= cmd_q.idx;
		end else if (frame_start) begin
			rd_pend_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			mtx_q      <= 16'h0000;
			mtx_pend_q <= 1'b0;
		end else if (mtx_set) begin
			mtx_q      <= pwdata[15:0];
			mtx_pend_q <= 1'b1;
		end else if (frame_start && en_q) begin
			mtx_pend_q <= 1'b0;
		end
	end

	// Tags of the input frame are fixed at its start
	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			rd_v_q    <= 1'b0;
			md_v_q    <= 1'b0;
			rd_data_q <= 16'h0000;
		end else if (frame_start) begin
			rd_v_q    <= rd_pend_q;
			md_v_q    <= mtx_pend_q & en_q;
			rd_data_q <= rd_idx_q[0] ? 16'h0000 : regs_q[rd_idx_q[6:1]];
		end
	end

	// ==========================================
	// Codec ready
	acl_ready_t rdy_q;
	logic [1:0] frm_cnt_q;

	always_ff @(posedge ref_clk_i) begin
		if (rst_all || warm) begin
			frm_cnt_q <= 2'h0;
			rdy_q     <= LS_NOT_READY;
		end else if (frame_start) begin
			unique case (rdy_q)
				LS_NOT_READY: begin
					frm_cnt_q <= frm_cnt_q + 2'h1;
					if (frm_cnt_q == 2'(READY_FRAMES - 1)) begin
						rdy_q <= LS_READY; // R21
					end
				end
				LS_READY: begin
					frm_cnt_q <= frm_cnt_q;
				end
			endcase
		end
	end

	// ==========================================
	// Input-line transmit
	logic [19:0] tx_word;
	logic        sdin_q;

	always_comb begin
		tx_word = 20'h00000; // R11
		unique case (pos.slot)
			4'h0:       tx_word = {4'h0, rdy_q == LS_READY, rd_v_q, rd_v_q, 2'h0, md_v_q, 10'h000}; // R10
			SLOT_CMD:   tx_word = rd_v_q ? {1'b0, rd_idx_q, 12'h000} : 20'h00000; // R22
			SLOT_DATA:  tx_word = rd_v_q ? {rd_data_q, 4'h0} : 20'h00000;
			SLOT_MODEM: tx_word = md_v_q ? {mtx_q, 4'h0} : 20'h00000;
			default:    tx_word = 20'h00000;
		endcase
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_all) begin
			sdin_q <= 1'b0; // R25
		end else if (rise) begin
			sdin_q <= in_frame ? tx_word[pos.bpos] : 1'b0; // R04 R25
		end
	end
	assign sdata_in_o = sdin_q; // R20

	// ==========================================
	// APB slave
	logic [31:0] prdata_q;
	logic        mapped;
	assign mapped = (paddr == ADDR_CTRL) | (paddr == ADDR_STATUS) | (paddr == ADDR_MRX)
		| (paddr == ADDR_MTX) | (paddr == ADDR_TAGS);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			en_q <= 1'b0;
		end else if (apb_wr && paddr == ADDR_CTRL) begin
			en_q <= pwdata[0];
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			prdata_q <= 32'h00000000;
		end else if (apb_rd) begin
			unique case (paddr)
				ADDR_CTRL:   prdata_q <= {31'h0, en_q};
				ADDR_STATUS: prdata_q <= {28'h0, tags_q[TAG_VALID], mtx_pend_q, mrx_new_q, rdy_q == LS_READY};
				ADDR_MRX:    prdata_q <= {16'h0, mrx_q};
				ADDR_MTX:    prdata_q <= {16'h0, mtx_q};
				ADDR_TAGS:   prdata_q <= {16'h0, tags_q};
				default:     prdata_q <= 32'h00000000;
			endcase
		end
	end
	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// ==========================================
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	chk_edge_launch: assert property ($changed(sdata_in_o) |-> $past(rise) || $past(rst_all)) // R04
		else $error("input-line data changed away from a bit clock rise");
	chk_frame_clear: assert property (frame_start && !warm && !rst_all |=> pos_q == 9'h000) // R24
		else $error("bit counter not cleared on sync rise");
	chk_pos_step: assert property (fall && in_frame && !frame_start && !warm && !rst_all // R01
		|=> pos_q == $past(pos_q) + 9'h001)
		else $error("bit counter did not advance on sampled bit");
	chk_cold_clear: assert property (!rstn_s2 |=> sdata_in_o == 1'b0 && regs_q[0] == REG_DEFAULT) // R05
		else $error("cold reset left state behind");
	chk_reg_reset: assert property (reg_wr && cmd_q.idx == REG_RESET_IDX // R07
		|=> regs_q[1] == REG_DEFAULT && rdy_q == $past(rdy_q))
		else $error("register reset wrong");
	chk_warm_keep: assert property (warm |=> regs_q[2] == $past(regs_q[2]) && pos_q == POS_IDLE) // R06
		else $error("warm reset altered registers");
	chk_slot_zero: assert property (rise && in_frame && pos.slot == SLOT_MODEM && !md_v_q && !rst_all // R11
		|=> !sdata_in_o)
		else $error("untagged slot not zero");
	chk_ready_bit: assert property (rise && pos_q == 9'h000 && !rst_all |=> sdata_in_o == (rdy_q == LS_READY)) // R21
		else $error("codec ready bit wrong");

endmodule

//--- verilog/acl_pkg.sv
// Constants, carriers and states for the AC-link secondary codec port
package acl_pkg;

	// ==========================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_MIN_NS  = 1000;
	localparam int WARM_CYC      = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READY_FRAMES  = 2;

	// ==========================================
	// Frame layout
	localparam int       TAG_BITS   = 16;
	localparam int       SLOT_BITS  = 20;
	localparam int       NUM_SLOTS  = 12;
	localparam logic [8:0] POS_IDLE = 9'h100;
	localparam logic [3:0] SLOT_CMD   = 4'h1;
	localparam logic [3:0] SLOT_DATA  = 4'h2;
	localparam logic [3:0] SLOT_MODEM = 4'h5;
	localparam int       TAG_VALID  = 15;
	localparam int       TAG_CMD    = 14;
	localparam int       TAG_DATA   = 13;
	localparam int       TAG_MODEM  = 10;

	// ==========================================
	// Codec register file
	localparam logic [6:0]  REG_RESET_IDX = 7'h3C;
	localparam logic [15:0] REG_DEFAULT   = 16'h0000;

	// ==========================================
	// APB register map
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_MRX    = 8'h08;
	localparam logic [7:0] ADDR_MTX    = 8'h0C;
	localparam logic [7:0] ADDR_TAGS   = 8'h10;

	typedef struct packed {
		logic [3:0] slot;
		logic [4:0] bpos;
	} acl_pos_t;

	typedef struct packed {
		logic       rd;
		logic [6:0] idx;
	} acl_cmd_t;

	typedef enum logic [0:0] {
		LS_NOT_READY = 1'b0,
		LS_READY     = 1'b1
	} acl_ready_t;

endpackage
